// ==== verilog/cfr_pkg.sv ====
/*
   Shared definitions of the core special-function register bank: location
   offsets, status and option bit positions, reset values and the packed
   carriers that join the bank to the CPU core.
   Assumes one 50 MHz clock domain shared with the CPU core.
*/
package cfr_pkg;

   // ----------------------------------------------------------------
   // Locations mirrored in both banks (low seven address bits)
   // ----------------------------------------------------------------
   localparam logic [6:0] MIR_INDIRECT = 7'h00;
   localparam logic [6:0] MIR_PCL = 7'h02;
   localparam logic [6:0] MIR_STATUS = 7'h03;
   localparam logic [6:0] MIR_POINTER = 7'h04;
   localparam logic [6:0] MIR_PCLATCH = 7'h0A;
   localparam logic [6:0] MIR_INTCTRL = 7'h0B;

   // ----------------------------------------------------------------
   // Full eight-bit locations, bank bit on top
   // ----------------------------------------------------------------
   localparam logic [7:0] LOC_TIMER0 = 8'h01;
   localparam logic [7:0] LOC_PORT_A_DATA = 8'h05;
   localparam logic [7:0] LOC_PORT_B_DATA = 8'h06;
   localparam logic [7:0] LOC_CAPPIN = 8'h07;
   localparam logic [7:0] LOC_IRQFLAGS = 8'h0C;
   localparam logic [7:0] LOC_T1LOW = 8'h0E;
   localparam logic [7:0] LOC_T1HIGH = 8'h0F;
   localparam logic [7:0] LOC_T1CTRL = 8'h10;
   localparam logic [7:0] LOC_T2COUNT = 8'h11;
   localparam logic [7:0] LOC_T2CTRL = 8'h12;
   localparam logic [7:0] LOC_CAPLOW = 8'h15;
   localparam logic [7:0] LOC_CAPHIGH = 8'h16;
   localparam logic [7:0] LOC_CAPCTRL = 8'h17;
   localparam logic [7:0] LOC_CONVRES = 8'h1E;
   localparam logic [7:0] LOC_CONVCTLA = 8'h1F;
   localparam logic [7:0] LOC_OPTION = 8'h81;
   localparam logic [7:0] LOC_PORT_A_DIRECTION = 8'h85;
   localparam logic [7:0] LOC_PORT_B_DIRECTION = 8'h86;
   localparam logic [7:0] LOC_TRISCAP = 8'h87;
   localparam logic [7:0] LOC_IRQENABLES = 8'h8C;
   localparam logic [7:0] LOC_RESETCAUSE = 8'h8E;
   localparam logic [7:0] LOC_T2PERIOD = 8'h92;
   localparam logic [7:0] LOC_CONVCTLB = 8'h9F;
   localparam logic [7:0] GPR0_LO = 8'h20;
   localparam logic [7:0] GPR0_HI = 8'h7F;
   localparam logic [7:0] GPR1_LO = 8'hA0;
   localparam logic [7:0] GPR1_HI = 8'hBF;

   // ----------------------------------------------------------------
   // Status and option bit positions
   // ----------------------------------------------------------------
   localparam int ST_IRP = 7;
   localparam int ST_RP1 = 6;
   localparam int ST_RP0 = 5;
   localparam int ST_TO = 4;
   localparam int ST_PD = 3;
   localparam int ST_Z = 2;
   localparam int ST_DC = 1;
   localparam int ST_C = 0;
   localparam int OP_PULLDIS = 7;
   localparam int OP_INTEDGE = 6;
   localparam int OP_T0SRC = 5;
   localparam int OP_T0EDGE = 4;
   localparam int OP_PSASSIGN = 3;

   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_POR = 8'h18;
   localparam logic [7:0] OPTION_RST = 8'hFF;
   localparam logic [7:0] PORT_B_DIRECTION_RST = 8'hFF;
   localparam logic [7:0] TRISCAP_SET = 8'h05;
   localparam logic [7:0] INTCTRL_KEEP = 8'h01;
   localparam logic [4:0] PCLATCH_RST = 5'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // Location classes and carriers
   // ----------------------------------------------------------------
   typedef enum {LK_NONE, LK_INDIRECT_DATA_PORT, LK_PCL, LK_STATUS, LK_POINTER, LK_PCLATCH,
      LK_INTCTRL, LK_OPTION, LK_PORT_A_DIRECTION, LK_PORT_B_DIRECTION, LK_TRISCAP, LK_EXT} cfr_loc_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } cfr_access_t;

   typedef struct packed {
      logic affectZ;
      logic affectDc;
      logic affectC;
      logic subtract;
      logic zero;
      logic digitRaw;
      logic carryRaw;
   } cfr_alu_t;

   typedef struct packed {
      logic sleep;
      logic clearWatchdog;
      logic watchdogTimeout;
      logic masterClear;
   } cfr_event_t;

   typedef struct packed {
      logic load;
      logic [12:0] value;
   } cfr_pcload_t;

endpackage

// ==== verilog/cfr_option_decode.sv ====
/*
   Registered decode of the option control byte into the controls used by
   timer0, the watchdog, the edge interrupt and the port B pull-ups.
   Assumes the option byte and port B direction come from the bank's flops.
*/
module cfr_option_decode
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Stored option and direction
   input wire logic [7:0] optionByte,
   input wire logic [7:0] dirB,
   // Decoded controls
   output logic [7:0] pullupEn,
   output logic intRising,
   output logic timer0External,
   output logic timer0Falling,
   output logic prescToWatchdog,
   output logic [3:0] timer0DivLog2,
   output logic [2:0] watchdogDivLog2
);
   import cfr_pkg::*;

   wire logic toWd = optionByte[OP_PSASSIGN];
   wire logic [2:0] rate = optionByte[2:0];
   // Timer0 runs 1:2 up to 1:256; undivided only when assigned away
   wire logic [3:0] t0Div = toWd ? 4'h0 : ({1'b0, rate} + 4'h1);
   wire logic [2:0] wdDiv = toWd ? rate : 3'h0;
   // Pull-ups only on pins set as inputs, and only with disable low
   wire logic [7:0] pullNext = optionByte[OP_PULLDIS] ? BYTE_ZERO : dirB;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pullupEn <= BYTE_ZERO;
         intRising <= 1'b1;
         timer0External <= 1'b1;
         timer0Falling <= 1'b1;
         prescToWatchdog <= 1'b1;
         timer0DivLog2 <= 4'h0;
         watchdogDivLog2 <= 3'h7;
      end
      else
      begin
         pullupEn <= pullNext;
         intRising <= optionByte[OP_INTEDGE];
         timer0External <= optionByte[OP_T0SRC];
         timer0Falling <= optionByte[OP_T0EDGE];
         prescToWatchdog <= toWd;
         timer0DivLog2 <= t0Div;
         watchdogDivLog2 <= wdDiv;
      end
   end

   chk_timer_rate: assert property (@(posedge mclk) disable iff (!rst_n)
      !optionByte[OP_PSASSIGN] |=> timer0DivLog2 == {1'b0, $past(optionByte[2:0])} + 4'h1)
      else $error("timer0 division does not follow rate field");
endmodule // cfr_option_decode

// ==== verilog/cfr_sfr_bank.sv ====
/*
   Core special-function register bank: status, option, program counter low
   byte and high latch, indirect pointer, interrupt control and the port
   direction registers, with decode of the two data banks and forwarding of
   peripheral and general-purpose locations to the outside.
   Assumes a CPU core on the same clock that issues one access at a time and
   waits for rdValid after a peripheral read before its next read.
*/
// Behaviour
// - core registers except option and port directions appear at the same storage in both data banks.
// - reads of unimplemented locations in the register area return zero.
// - writing the low PC byte loads upper PC bits from the high latch.
// - power-on resets and other resets load their own separate values.
// - any reset sets port A and B direction bits and capture direction bits 0 and 2, making those pins inputs.
// - one status register holds ALU flags, reset cause and bank select.
// - instructions affecting zero, digit carry or carry override status writes.
// - software writes to timeout and power-down flags are ignored.
// - clearing status clears upper bits, keeps reset flags, sets zero.
// - in subtraction carry and digit carry act as active-low borrows.
// - option register configures prescaler, interrupt edge, timer0 source, pull-ups.
// - pull-up disable bit one disables all port B pull-ups.
// - rate field divides timer0 1:2..1:256 or watchdog 1:1..1:128.
// - registers are static storage, core set here, peripheral set outside.
// - bank select 00 picks bank 0, 01 bank 1; banks 2, 3 absent.
module cfr_sfr_bank
#(
   parameter int PORT_A_DATA_W = 6
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // CPU register access
   input wire cfr_pkg::cfr_access_t access,
   output logic [7:0] rdData,
   output logic rdValid,
   // ALU flag results and device events
   input wire cfr_pkg::cfr_alu_t alu,
   input wire cfr_pkg::cfr_event_t events,
   // Program counter
   input wire cfr_pkg::cfr_pcload_t pcLoad,
   output logic [12:0] pcValue,
   output logic [4:0] pcLatch,
   // Core register contents
   output logic [7:0] statusFlags,
   output logic [7:0] indirectPtr,
   output logic [7:0] intCtrl,
   input wire logic [2:0] intFlagSet,
   output logic [7:0] dirA,
   output logic [7:0] dirB,
   output logic [7:0] dirCap,
   // Peripheral and general-purpose locations
   output logic periphWr,
   output logic periphRd,
   output logic [7:0] periphAddr,
   output logic [7:0] periphWdata,
   input wire logic [7:0] periphRdData,
   // Option decode
   output logic [7:0] pullupEn,
   output logic intRising,
   output logic timer0External,
   output logic timer0Falling,
   output logic prescToWatchdog,
   output logic [3:0] timer0DivLog2,
   output logic [2:0] watchdogDivLog2
);
   import cfr_pkg::*;

   // Port A width must fit the byte-wide direction register
   if (PORT_A_DATA_W < 1 || PORT_A_DATA_W > 8)
   begin : g_bad_port_a_data_w
      $error("PORT_A_DATA_W must lie between 1 and 8");
   end

   localparam logic [7:0] PORT_A_DIRECTION_RST = 8'((1 << PORT_A_DATA_W) - 1);

   // ----------------------------------------------------------------
   // Location decode
   // ----------------------------------------------------------------
   function automatic cfr_loc_t cfr_classify(input logic [8:0] loc);
      cfr_loc_t kind;
      kind = LK_NONE;
      if (!loc[8])
      begin
         case (loc[6:0])
            MIR_INDIRECT: kind = LK_INDIRECT_DATA_PORT;
            MIR_PCL: kind = LK_PCL;
            MIR_STATUS: kind = LK_STATUS;
            MIR_POINTER: kind = LK_POINTER;
            MIR_PCLATCH: kind = LK_PCLATCH;
            MIR_INTCTRL: kind = LK_INTCTRL;
            default:
            begin
               case (loc[7:0])
                  LOC_OPTION: kind = LK_OPTION;
                  LOC_PORT_A_DIRECTION: kind = LK_PORT_A_DIRECTION;
                  LOC_PORT_B_DIRECTION: kind = LK_PORT_B_DIRECTION;
                  LOC_TRISCAP: kind = LK_TRISCAP;
                  LOC_TIMER0, LOC_PORT_A_DATA, LOC_PORT_B_DATA, LOC_CAPPIN, LOC_IRQFLAGS,
                  LOC_T1LOW, LOC_T1HIGH, LOC_T1CTRL, LOC_T2COUNT, LOC_T2CTRL,
                  LOC_CAPLOW, LOC_CAPHIGH, LOC_CAPCTRL, LOC_CONVRES, LOC_CONVCTLA,
                  LOC_IRQENABLES, LOC_RESETCAUSE, LOC_T2PERIOD, LOC_CONVCTLB:
                     kind = LK_EXT;
                  default:
                  begin
                     if ((loc[7:0] >= GPR0_LO && loc[7:0] <= GPR0_HI) ||
                         (loc[7:0] >= GPR1_LO && loc[7:0] <= GPR1_HI))
                        kind = LK_EXT;
                  end
               endcase
            end
         endcase
      end
      return kind;
   endfunction

   logic [7:0] status_reg, status_next;
   logic [7:0] option_reg;
   logic [7:0] pointer_reg;
   logic [4:0] pcLatch_reg;
   logic [12:0] pc_reg;
   logic [7:0] intCtrl_reg, intCtrl_next;
   logic [7:0] dirA_reg, dirB_reg, dirCap_reg;
   logic [7:0] rdData_reg;
   logic rdValid_reg;
   logic extPending_reg;
   logic periphWr_reg;
   logic [7:0] periphAddr_reg, periphWdata_reg;

   // Indirect port replaces the address with the pointer; bank bits unused
   wire logic useIndirect = (access.addr == MIR_INDIRECT);
   wire logic [8:0] directLoc = {status_reg[ST_RP1], status_reg[ST_RP0], access.addr};
   wire logic [8:0] targetLoc = useIndirect ? {1'b0, pointer_reg} : directLoc;
   // Enum is two-state, so it cannot be a net
   cfr_loc_t locKind;
   assign locKind = cfr_classify(targetLoc);
   wire logic wrHit = access.wr;
   wire logic wrStatus = wrHit && locKind == LK_STATUS;
   wire logic otherReset = events.masterClear || events.watchdogTimeout;

   // ----------------------------------------------------------------
   // Read selection
   // ----------------------------------------------------------------
   logic [7:0] rdValue;
   always_comb
   begin
      rdValue = BYTE_ZERO;
      case (locKind)
         LK_PCL: rdValue = pc_reg[7:0];
         LK_STATUS: rdValue = status_reg;
         LK_POINTER: rdValue = pointer_reg;
         LK_PCLATCH: rdValue = {3'h0, pcLatch_reg};
         LK_INTCTRL: rdValue = intCtrl_reg;
         LK_OPTION: rdValue = option_reg;
         LK_PORT_A_DIRECTION: rdValue = dirA_reg;
         LK_PORT_B_DIRECTION: rdValue = dirB_reg;
         LK_TRISCAP: rdValue = dirCap_reg;
         default: rdValue = BYTE_ZERO;
      endcase
   end

   // ----------------------------------------------------------------
   // Status next value
   // ----------------------------------------------------------------
   // borrow polarity reversed
   wire logic carryFlag = alu.subtract ? ~alu.carryRaw : alu.carryRaw;
   wire logic digitFlag = alu.subtract ? ~alu.digitRaw : alu.digitRaw;
   always_comb
   begin
      status_next = status_reg;
      if (wrStatus)
      begin
         status_next[ST_IRP] = access.wdata[ST_IRP];
         status_next[ST_RP1] = access.wdata[ST_RP1];
         status_next[ST_RP0] = access.wdata[ST_RP0];
         status_next[ST_Z] = access.wdata[ST_Z];
         status_next[ST_DC] = access.wdata[ST_DC];
         status_next[ST_C] = access.wdata[ST_C];
      end
      // ALU result wins over the written flags
      // clearing status keeps reset flags, zero comes from the ALU
      if (alu.affectZ)
         status_next[ST_Z] = alu.zero;
      if (alu.affectDc)
         status_next[ST_DC] = digitFlag;
      if (alu.affectC)
         status_next[ST_C] = carryFlag;
      if (events.clearWatchdog)
      begin
         status_next[ST_TO] = 1'b1;
         status_next[ST_PD] = 1'b1;
      end
      if (events.sleep)
      begin
         status_next[ST_TO] = 1'b1;
         status_next[ST_PD] = 1'b0;
      end
      if (otherReset)
      begin
         status_next[ST_IRP] = 1'b0;
         status_next[ST_RP1] = 1'b0;
         status_next[ST_RP0] = 1'b0;
         if (events.watchdogTimeout)
            status_next[ST_TO] = 1'b0;
      end
   end

   // Hardware interrupt flags win over a software clear
   always_comb
   begin
      intCtrl_next = intCtrl_reg;
      if (wrHit && locKind == LK_INTCTRL)
         intCtrl_next = access.wdata;
      intCtrl_next[2:0] = intCtrl_next[2:0] | intFlagSet;
      if (otherReset)
         intCtrl_next = intCtrl_reg & INTCTRL_KEEP;
   end

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   // core set held in flops
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_reg <= STATUS_POR;
         intCtrl_reg <= BYTE_ZERO;
         pointer_reg <= BYTE_ZERO;
      end
      else
      begin
         status_reg <= status_next;
         intCtrl_reg <= intCtrl_next;
         if (!otherReset && wrHit && locKind == LK_POINTER)
            pointer_reg <= access.wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         option_reg <= OPTION_RST;
         dirA_reg <= PORT_A_DIRECTION_RST;
         dirB_reg <= PORT_B_DIRECTION_RST;
         dirCap_reg <= TRISCAP_SET;
      end
      else if (otherReset)
      begin
         option_reg <= OPTION_RST;
         dirA_reg <= PORT_A_DIRECTION_RST;
         dirB_reg <= PORT_B_DIRECTION_RST;
         dirCap_reg <= dirCap_reg | TRISCAP_SET;
      end
      else if (wrHit)
      begin
         if (locKind == LK_OPTION)
            option_reg <= access.wdata;
         if (locKind == LK_PORT_A_DIRECTION)
            dirA_reg <= access.wdata & PORT_A_DIRECTION_RST;
         if (locKind == LK_PORT_B_DIRECTION)
            dirB_reg <= access.wdata;
         if (locKind == LK_TRISCAP)
            dirCap_reg <= access.wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pcLatch_reg <= PCLATCH_RST;
         pc_reg <= 13'h0000;
      end
      else if (otherReset)
      begin
         pcLatch_reg <= PCLATCH_RST;
         pc_reg <= 13'h0000;
      end
      else
      begin
         if (wrHit && locKind == LK_PCLATCH)
            pcLatch_reg <= access.wdata[4:0];
         // upper bits come only from the latch
         if (wrHit && locKind == LK_PCL)
            pc_reg <= {pcLatch_reg, access.wdata};
         else if (pcLoad.load)
            pc_reg <= pcLoad.value;
      end
   end

   // ----------------------------------------------------------------
   // Read return and peripheral forwarding
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdData_reg <= BYTE_ZERO;
         rdValid_reg <= 1'b0;
         extPending_reg <= 1'b0;
      end
      else
      begin
         extPending_reg <= access.rd && locKind == LK_EXT;
         rdValid_reg <= (access.rd && locKind != LK_EXT) || extPending_reg;
         if (extPending_reg)
            rdData_reg <= periphRdData;
         else if (access.rd)
            rdData_reg <= rdValue;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         periphWr_reg <= 1'b0;
         periphAddr_reg <= BYTE_ZERO;
         periphWdata_reg <= BYTE_ZERO;
      end
      else
      begin
         periphWr_reg <= wrHit && locKind == LK_EXT;
         if ((access.rd || wrHit) && locKind == LK_EXT)
         begin
            periphAddr_reg <= targetLoc[7:0];
            periphWdata_reg <= access.wdata;
         end
      end
   end

   cfr_option_decode u_option
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .optionByte(option_reg),
      .dirB(dirB_reg),
      .pullupEn(pullupEn),
      .intRising(intRising),
      .timer0External(timer0External),
      .timer0Falling(timer0Falling),
      .prescToWatchdog(prescToWatchdog),
      .timer0DivLog2(timer0DivLog2),
      .watchdogDivLog2(watchdogDivLog2)
   );

   assign rdData = rdData_reg;
   assign rdValid = rdValid_reg;
   assign pcValue = pc_reg;
   assign pcLatch = pcLatch_reg;
   assign statusFlags = status_reg;
   assign indirectPtr = pointer_reg;
   assign intCtrl = intCtrl_reg;
   assign dirA = dirA_reg;
   assign dirB = dirB_reg;
   assign dirCap = dirCap_reg;
   assign periphWr = periphWr_reg;
   assign periphRd = extPending_reg;
   assign periphAddr = periphAddr_reg;
   assign periphWdata = periphWdata_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_mirror_status: assert property (@(posedge mclk) disable iff (!rst_n)
      access.rd && !useIndirect && access.addr == MIR_STATUS && !status_reg[ST_RP1]
      |=> rdValid && rdData == $past(status_reg))
      else $error("status read differs between banks");

   chk_gap_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      access.rd && locKind == LK_NONE |=> rdValid && rdData == BYTE_ZERO)
      else $error("unimplemented location read nonzero");

   chk_pc_transfer: assert property (@(posedge mclk) disable iff (!rst_n)
      wrHit && locKind == LK_PCL && !otherReset
      |=> pc_reg[12:8] == $past(pcLatch_reg) && pc_reg[7:0] == $past(access.wdata))
      else $error("program counter high bits not taken from latch");

   chk_other_reset: assert property (@(posedge mclk) disable iff (!rst_n)
      otherReset |=> option_reg == OPTION_RST && !status_reg[ST_RP0] && pc_reg == 13'h0000)
      else $error("other reset values not applied");

   chk_dir_inputs: assert property (@(posedge mclk) disable iff (!rst_n)
      otherReset |=> dirB_reg == PORT_B_DIRECTION_RST && dirCap_reg[2] && dirCap_reg[0])
      else $error("port pins not made inputs on reset");

   chk_flag_block: assert property (@(posedge mclk) disable iff (!rst_n)
      wrStatus && alu.affectZ && !otherReset |=> status_reg[ST_Z] == $past(alu.zero))
      else $error("written zero flag overrode the result");

   chk_ro_flags: assert property (@(posedge mclk) disable iff (!rst_n)
      wrStatus && !events.sleep && !events.clearWatchdog && !otherReset
      |=> $stable(status_reg[ST_TO:ST_PD]))
      else $error("software changed timeout or power-down flag");

   chk_borrow_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
      alu.affectC && alu.subtract |=> status_reg[ST_C] == !$past(alu.carryRaw))
      else $error("borrow polarity wrong");

   chk_timeout_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      events.sleep && !otherReset |=> status_reg[ST_TO] && !status_reg[ST_PD])
      else $error("sleep did not set reset flags");
endmodule // cfr_sfr_bank

// ==== dv/cfr_periph_model.sv ====
/*
   Peripheral-side storage that answers the bank's forwarded accesses.
   Assumes one-cycle strobes on mclk and a read sampled while periphRd is high.
*/
module cfr_periph_model
(
   // Clock
   input wire logic mclk,
   // Forwarded access
   input wire logic periphWr,
   input wire logic periphRd,
   input wire logic [7:0] periphAddr,
   input wire logic [7:0] periphWdata,
   output logic [7:0] periphRdData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [7:0] lastReg = 8'h00;
   always_ff @(posedge mclk)
   begin
      if (periphWr)
         mem[periphAddr] <= periphWdata;
      lastReg <= periphRdData;
   end
   // Idle bus inverts, so a stale value cannot pass
   assign periphRdData = periphRd ? mem[periphAddr] : ~lastReg;
endmodule // cfr_periph_model

// ==== dv/tb_cfr_sfr_bank.sv ====
/*
   Self-checking bench of the register bank: register accesses, flag updates,
   option decode and resets. Assumes the peripheral model on the forward port.
*/
module tb_cfr_sfr_bank;
   import cfr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rst_n = 0, pWr, pRd;
   logic [7:0] pAddr, pWdata, pRdData, rdData, d;
   logic rdValid;
   cfr_access_t acc = '0;
   cfr_alu_t alu = '0;
   cfr_event_t ev = '0;
   logic [12:0] pcValue;
   logic [4:0] pcLatch;
   logic [7:0] st, dirB, pullupEn;
   logic [7:0] indirectPtr, intCtrl, dirA, dirCap;
   logic intR, t0Ext, t0Fall, psWd;
   logic [3:0] t0Div;
   logic [2:0] wdDiv;
   int nMismatch = 0, nTests = 0;
   always #10 mclk = ~mclk;
   cfr_sfr_bank i_dut (.mclk(mclk), .rst_n(rst_n), .access(acc), .rdData(rdData), .rdValid(rdValid),
      .alu(alu), .events(ev), .pcLoad('0), .pcValue(pcValue), .pcLatch(pcLatch), .statusFlags(st),
      .indirectPtr(indirectPtr), .intCtrl(intCtrl), .intFlagSet(3'h0), .dirA(dirA), .dirB(dirB),
      .dirCap(dirCap),
      .periphWr(pWr), .periphRd(pRd), .periphAddr(pAddr), .periphWdata(pWdata), .periphRdData(pRdData),
      .pullupEn(pullupEn), .intRising(intR), .timer0External(t0Ext), .timer0Falling(t0Fall),
      .prescToWatchdog(psWd), .timer0DivLog2(t0Div), .watchdogDivLog2(wdDiv));
   cfr_periph_model i_periph (.mclk(mclk), .periphWr(pWr), .periphRd(pRd), .periphAddr(pAddr),
      .periphWdata(pWdata), .periphRdData(pRdData));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One request cycle, optional ALU result alongside
   task automatic wr(input logic [6:0] a, input logic [7:0] v, input logic [6:0] f = 7'h00);
      acc = {1'b0, 1'b1, a, v};
      alu = f;
      @(posedge mclk);
      #1 acc = '0;
      alu = '0;
      // Idle edge, so the next request is never set in the same step
      @(posedge mclk) #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      acc = {1'b1, 1'b0, a, 8'h00};
      @(posedge mclk);
      #1 acc = '0;
      for (int i = 0; i < 4 && rdValid !== 1'b1; i++)
         @(posedge mclk) #1;
      // A read that never completes must not pass on stale data
      chk({7'h00, rdValid, rdData}, {8'h01, exp});
      @(posedge mclk) #1;
   endtask
   task automatic pulse(input logic [3:0] e);
      ev = e;
      @(posedge mclk);
      #1 ev = '0;
      @(posedge mclk) #1;
   endtask
   task automatic wrapUp;
      $display("comparisons %0d mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #10us nMismatch++;
      wrapUp();
   end
   initial
   begin
      repeat (4) @(posedge mclk);
      #1 rst_n = 1;
      rd(7'h03, 8'h18);
      rd(7'h08, 8'h00);
      pulse(4'h8);
      // Flags kept, bank 1 selected, reserved bank bits left clear
      wr(7'h03, 8'h2F);
      chk({8'h00, st}, 16'h0037);
      rd(7'h01, 8'hFF);
      rd(7'h0F, 8'h00);
      wr(7'h01, 8'h05);
      wr(7'h04, 8'h5A);
      wr(7'h06, 8'h0F);
      @(posedge mclk) #1;
      chk({3'h0, t0Div, psWd, pullupEn}, {3'h0, 4'd6, 1'b0, 8'h0F});
      chk({8'h00, pullupEn}, 16'h000F);
      wr(7'h01, 8'h8B);
      @(posedge mclk) #1;
      chk({1'b0, pullupEn, intR, t0Ext, t0Fall, psWd, wdDiv}, {1'b0, 8'h00, 4'b0001, 3'd3});
      chk({12'h000, t0Div}, 16'h0000);
      wr(7'h03, 8'h00);
      rd(7'h04, 8'h5A);
      wr(7'h0A, 8'h15);
      wr(7'h02, 8'h34);
      chk({3'h0, pcValue}, 16'h1534);
      wr(7'h0E, 8'hAB);
      rd(7'h0E, 8'hAB);
      wr(7'h03, 8'h00, 7'h44);
      chk({8'h00, st}, 16'h0014);
      // Raw carry and digit differ, so a swapped or missing inversion shows
      wr(7'h05, 8'h00, 7'h39);
      chk({8'h00, st}, 16'h0016);
      wr(7'h0B, 8'hC1);
      pulse(4'h1);
      chk({3'h0, pcValue}, 16'h0000);
      chk({11'h000, pcLatch}, 16'h0000);
      chk({intCtrl, indirectPtr}, 16'h015A);
      chk({st, dirB}, 16'h16FF);
      chk({dirA, dirCap}, 16'h3F05);
      wrapUp();
   end
endmodule // tb_cfr_sfr_bank
